/* crf_pkg.sv */
package crf_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DATA_W  = 16;
  localparam int ADDR_W  = 24;
  localparam int MODE_W  = 8;
  localparam int BYTE_W  = 8;
  localparam int LONG_W  = 32;

  // ----------------------------------------------------------------
  // Flag bit positions
  // ----------------------------------------------------------------
  localparam int FLG_CARRY = 0;
  localparam int FLG_STEP  = 1;
  localparam int FLG_ZERO  = 2;
  localparam int FLG_SIGN  = 3;
  localparam int FLG_BANK  = 4;
  localparam int FLG_OVFL  = 5;
  localparam int FLG_IEN   = 6;
  localparam int FLG_STACK = 7;
  localparam int FLG_PRI_LO = 12;
  localparam int FLG_PRI_HI = 14;

  // Writable bits: 0..7 and 12..14, reserved bits read zero
  localparam logic [15:0] FLG_WMASK = 16'h70FF;
  localparam logic [15:0] FLG_RESET = 16'h0000;

  // Software interrupt numbers below this clear the stack select
  localparam logic [5:0] SWI_STACK_LIMIT = 6'h20;

  // ----------------------------------------------------------------
  // Register selectors
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    CRF_SEL_D0     = 5'h00,
    CRF_SEL_D1     = 5'h01,
    CRF_SEL_D2     = 5'h02,
    CRF_SEL_D3     = 5'h03,
    CRF_SEL_D0L    = 5'h04,
    CRF_SEL_D0H    = 5'h05,
    CRF_SEL_D1L    = 5'h06,
    CRF_SEL_D1H    = 5'h07,
    CRF_SEL_LONGLO = 5'h08,
    CRF_SEL_LONGHI = 5'h09,
    CRF_SEL_P0     = 5'h0A,
    CRF_SEL_P1     = 5'h0B,
    CRF_SEL_SB     = 5'h0C,
    CRF_SEL_FB     = 5'h0D,
    CRF_SEL_VTB    = 5'h0E,
    CRF_SEL_USP    = 5'h0F,
    CRF_SEL_ISP    = 5'h10,
    CRF_SEL_SP     = 5'h11,
    CRF_SEL_FLG    = 5'h12,
    CRF_SEL_SVF    = 5'h13,
    CRF_SEL_SVP    = 5'h14,
    CRF_SEL_VCT    = 5'h15,
    CRF_SEL_PC     = 5'h16
  } crf_sel_t;

  typedef enum logic [2:0] {
    CRF_DMA_MODE   = 3'h0,
    CRF_DMA_COUNT  = 3'h1,
    CRF_DMA_CRLD   = 3'h2,
    CRF_DMA_MADDR  = 3'h3,
    CRF_DMA_FADDR  = 3'h4,
    CRF_DMA_ARLD   = 3'h5
  } crf_dma_sel_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        wr;
    crf_sel_t    sel;
    logic [31:0] data;
  } crf_wr_t;

  typedef struct packed {
    logic         wr;
    logic         chan;
    crf_dma_sel_t sel;
    logic [23:0]  data;
  } crf_dma_wr_t;

  typedef struct packed {
    logic carry_we;
    logic carry;
    logic zero_we;
    logic zero;
    logic sign_we;
    logic sign;
    logic ovfl_we;
    logic ovfl;
  } crf_alu_t;

  typedef struct packed {
    logic       hw_ack;
    logic       sw_int;
    logic [5:0] sw_num;
    logic       fast;
  } crf_irq_t;

endpackage

/* crf_bank.sv */
`timescale 1ns/100ps
// Single register bank: four data, two pointer, two base registers
module crf_bank
  import crf_pkg::*;
(
  // Clock and control
  input  wire logic                 clk_in,
  input  wire logic                 rstn_in,
  input  wire logic                 ce_in,
  // Write port
  input  wire logic                 we_in,
  input  wire crf_pkg::crf_sel_t    sel_in,
  input  wire logic [31:0]          data_in,
  // Contents
  output logic [4*16-1:0]           data_out,
  output logic [4*24-1:0]           addr_out
);

  logic [15:0] d_r [4];
  logic [23:0] a_r [4];

  // ------------------------------------------------------------
  // Data registers with byte halves and long pairs
  // ------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < 4; i++) begin
        d_r[i] <= 16'h0000; // RQ23
      end
    end else if (ce_in && we_in) begin
      unique case (sel_in)
        CRF_SEL_D0: d_r[0] <= data_in[15:0]; // RQ1
        CRF_SEL_D1: d_r[1] <= data_in[15:0];
        CRF_SEL_D2: d_r[2] <= data_in[15:0];
        CRF_SEL_D3: d_r[3] <= data_in[15:0];
        CRF_SEL_D0L: d_r[0][7:0]  <= data_in[7:0]; // RQ2
        CRF_SEL_D0H: d_r[0][15:8] <= data_in[7:0]; // RQ2
        CRF_SEL_D1L: d_r[1][7:0]  <= data_in[7:0];
        CRF_SEL_D1H: d_r[1][15:8] <= data_in[7:0];
        CRF_SEL_LONGLO: begin
          d_r[2] <= data_in[31:16]; // RQ3
          d_r[0] <= data_in[15:0];
        end
        CRF_SEL_LONGHI: begin
          d_r[3] <= data_in[31:16]; // RQ3
          d_r[1] <= data_in[15:0];
        end
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Pointer and base registers (0,1 pointers, 2 static, 3 frame)
  // ------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < 4; i++) begin
        a_r[i] <= 24'h000000; // RQ23
      end
    end else if (ce_in && we_in) begin
      unique case (sel_in)
        CRF_SEL_P0: a_r[0] <= data_in[23:0]; // RQ4
        CRF_SEL_P1: a_r[1] <= data_in[23:0];
        CRF_SEL_SB: a_r[2] <= data_in[23:0]; // RQ7
        CRF_SEL_FB: a_r[3] <= data_in[23:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      data_out[i*16 +: 16] = d_r[i];
      addr_out[i*24 +: 24] = a_r[i];
    end
  end

endmodule

/* crf_top.sv */
`timescale 1ns/100ps
// ------------------------------------------------------------------
// Summary of operation
// RQ1 - Four 16-bit data registers for transfers and arithmetic.
// RQ2 - Data zero and one split into byte halves; other half kept.
// RQ3 - Pairs two/zero and three/one form 32-bit words, high on top.
// RQ4 - Two 24-bit pointer registers for indirect and relative access.
// RQ5 - Data, pointer and base registers exist in two banks.
// RQ6 - Flag bit 4 selects bank zero or bank one.
// RQ7 - Static and frame base registers are 24 bits.
// RQ8 - Program counter is 24 bits, next instruction address.
// RQ9 - Vector table base is 24 bits.
// RQ10 - Flag bit 7 picks irq stack (0) or user stack (1).
// RQ11 - Stack select clears on hardware interrupt or soft interrupt 0-31.
// RQ12 - Software should keep both stack pointers even.
// RQ13 - Flag bit 0 captures ALU carry, borrow or shifted-out bit.
// RQ14 - Flag bit 1 requests single-step trap; clears on interrupt accept.
// RQ15 - Flag bits 2 and 3 track zero and negative results.
// RQ16 - Flag bit 5 set on arithmetic overflow.
// RQ17 - Flag bit 6 enables maskable interrupts; clears on accept.
// RQ18 - Flag bits 12-14 hold priority; interrupt allowed only if higher.
// RQ19 - Flag bits 8-11 and 15 are reserved, read zero.
// RQ20 - Fast interrupt saves flags and program counter; svp_r keeps only program counter bits 15:0.
// RQ21 - 24-bit fast interrupt target register.
// RQ22 - Two transfer channels with mode, count and address registers.
// RQ23 - Reset zeroes architectural registers; transfer data undefined. svf_r, svp_r and vct_r get no reset.
// RQ24 - Bank switch redirects access, no copying, banks retain data.
// ------------------------------------------------------------------
module crf_top
  import crf_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                  sys_clk_in,
  input  wire logic                  rstn_in,
  input  wire logic                  ce_in,
  // Register write port and read select
  input  wire crf_pkg::crf_wr_t      wr_in,
  input  wire crf_pkg::crf_sel_t     rd_sel_in,
  // Transfer channel port
  input  wire crf_pkg::crf_dma_wr_t  dma_wr_in,
  input  wire logic                  dma_rd_chan_in,
  input  wire crf_pkg::crf_dma_sel_t dma_rd_sel_in,
  // Datapath updates
  input  wire crf_pkg::crf_alu_t     alu_in,
  input  wire logic                  pc_we_in,
  input  wire logic [23:0]           pc_in,
  input  wire crf_pkg::crf_irq_t     irq_in,
  input  wire logic                  insn_done_in,
  input  wire logic [2:0]            req_pri_in,
  // Read data and status
  output logic [31:0]                rd_data_out,
  output logic [23:0]                dma_rd_data_out,
  output logic [15:0]                flags_out,
  output logic [23:0]                pc_out,
  output logic [23:0]                sp_out,
  output logic [23:0]                vtb_out,
  output logic [23:0]                fast_target_out,
  output logic [23:0]                ptr0_out,
  output logic [23:0]                ptr1_out,
  output logic [23:0]                sb_out,
  output logic [23:0]                fb_out,
  output logic                       irq_allowed_out,
  output logic                       step_trap_out
);

  // ------------------------------------------------------------
  // Reset synchroniser
  // ------------------------------------------------------------
  logic rst_meta_r;
  logic rst_sync_r;

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  logic rstn;
  assign rstn = rst_sync_r;

  // ------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------
  function automatic logic is_banked(input crf_sel_t s);
    is_banked = (s <= CRF_SEL_FB);
  endfunction

  function automatic logic [15:0] flg_merge(input logic [15:0] old_v,
                                            input logic [15:0] new_v);
    flg_merge = (old_v & ~FLG_WMASK) | (new_v & FLG_WMASK);
  endfunction

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [15:0] flg_r;
  logic [15:0] flg_nxt;
  logic [23:0] pc_r;
  logic [23:0] vtb_r;
  logic [23:0] usp_r;
  logic [23:0] isp_r;
  logic [15:0] svf_r;
  logic [15:0] svp_r;
  logic [23:0] vct_r;
  logic [7:0]  mode_r  [2];
  logic [15:0] cnt_r   [2];
  logic [15:0] crld_r  [2];
  logic [23:0] maddr_r [2];
  logic [23:0] faddr_r [2];
  logic [23:0] arld_r  [2];

  logic        bank_sel;
  logic        fw;
  assign bank_sel = flg_r[FLG_BANK];
  assign fw = ce_in && wr_in.wr;

  // ------------------------------------------------------------
  // Two banks; only the selected one sees writes
  // ------------------------------------------------------------
  logic [63:0] bank_d [2];
  logic [95:0] bank_a [2];

  for (genvar b = 0; b < 2; b++) begin : g_bank
    crf_bank u_bank (
      .clk_in   (sys_clk_in),
      .rstn_in  (rstn),
      .ce_in    (ce_in),
      .we_in    (wr_in.wr && (bank_sel == b[0])), // RQ5 RQ24
      .sel_in   (wr_in.sel),
      .data_in  (wr_in.data),
      .data_out (bank_d[b]),
      .addr_out (bank_a[b])
    );
  end

  // Active bank contents
  logic [63:0] cur_d;
  logic [95:0] cur_a;
  assign cur_d = bank_d[bank_sel]; // RQ6
  assign cur_a = bank_a[bank_sel];

  // ------------------------------------------------------------
  // Flag register next value
  // ------------------------------------------------------------
  always_comb begin
    flg_nxt = flg_r;
    if (fw && wr_in.sel == CRF_SEL_FLG) begin
      flg_nxt = flg_merge(flg_r, wr_in.data[15:0]); // RQ19
    end
    // ALU results take priority over a plain write
    if (alu_in.carry_we) flg_nxt[FLG_CARRY] = alu_in.carry; // RQ13
    if (alu_in.zero_we)  flg_nxt[FLG_ZERO]  = alu_in.zero;  // RQ15
    if (alu_in.sign_we)  flg_nxt[FLG_SIGN]  = alu_in.sign;  // RQ15
    if (alu_in.ovfl_we)  flg_nxt[FLG_OVFL]  = alu_in.ovfl;  // RQ16
    // Interrupt acceptance clears enable and step; stack select too, except soft interrupts 32-63
    if (irq_in.hw_ack || irq_in.fast) begin
      flg_nxt[FLG_IEN]   = 1'b0; // RQ17
      flg_nxt[FLG_STEP]  = 1'b0; // RQ14
      flg_nxt[FLG_STACK] = 1'b0; // RQ11
    end
    if (irq_in.sw_int) begin
      flg_nxt[FLG_IEN]  = 1'b0;
      flg_nxt[FLG_STEP] = 1'b0; // RQ14
      if (irq_in.sw_num < SWI_STACK_LIMIT) begin
        flg_nxt[FLG_STACK] = 1'b0; // RQ11
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn) begin
    if (!rstn) begin
      flg_r <= FLG_RESET; // RQ23
    end else if (ce_in) begin
      flg_r <= flg_nxt;
    end
  end

  // ------------------------------------------------------------
  // Program counter, table base, stack pointers
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rstn) begin
    if (!rstn) begin
      pc_r  <= 24'h000000;
      vtb_r <= 24'h000000; // RQ23
      usp_r <= 24'h000000;
      isp_r <= 24'h000000;
    end else if (ce_in) begin
      if (pc_we_in) pc_r <= pc_in; // RQ8
      if (fw && wr_in.sel == CRF_SEL_VTB) vtb_r <= wr_in.data[23:0]; // RQ9
      // Odd stack values are kept; software keeps them even (RQ12)
      if (fw && (wr_in.sel == CRF_SEL_USP ||
                 (wr_in.sel == CRF_SEL_SP && flg_r[FLG_STACK]))) begin
        usp_r <= wr_in.data[23:0]; // RQ10
      end
      if (fw && (wr_in.sel == CRF_SEL_ISP ||
                 (wr_in.sel == CRF_SEL_SP && !flg_r[FLG_STACK]))) begin
        isp_r <= wr_in.data[23:0]; // RQ10
      end
    end
  end

  // ------------------------------------------------------------
  // Fast interrupt save area; undefined at reset, so no reset
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (ce_in) begin
      if (irq_in.fast) begin
        svf_r <= flg_r; // RQ20
        svp_r <= pc_r[15:0]; // RQ20
      end else begin
        if (fw && wr_in.sel == CRF_SEL_SVF) svf_r <= wr_in.data[15:0];
        if (fw && wr_in.sel == CRF_SEL_SVP) svp_r <= wr_in.data[15:0];
      end
      if (fw && wr_in.sel == CRF_SEL_VCT) vct_r <= wr_in.data[23:0]; // RQ21
    end
  end

  // ------------------------------------------------------------
  // Transfer channel mode registers (reset to zero)
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rstn) begin
    if (!rstn) begin
      mode_r[0] <= 8'h00; // RQ23
      mode_r[1] <= 8'h00;
    end else if (ce_in && dma_wr_in.wr &&
                 dma_wr_in.sel == CRF_DMA_MODE) begin
      mode_r[dma_wr_in.chan] <= dma_wr_in.data[7:0]; // RQ22
    end
  end

  // Counts and addresses are undefined after reset
  always_ff @(posedge sys_clk_in) begin
    if (ce_in && dma_wr_in.wr) begin
      unique case (dma_wr_in.sel)
        CRF_DMA_COUNT: cnt_r[dma_wr_in.chan]   <= dma_wr_in.data[15:0];
        CRF_DMA_CRLD:  crld_r[dma_wr_in.chan]  <= dma_wr_in.data[15:0];
        CRF_DMA_MADDR: maddr_r[dma_wr_in.chan] <= dma_wr_in.data; // RQ22
        CRF_DMA_FADDR: faddr_r[dma_wr_in.chan] <= dma_wr_in.data;
        CRF_DMA_ARLD:  arld_r[dma_wr_in.chan]  <= dma_wr_in.data;
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Read multiplexers (registered data outputs)
  // ------------------------------------------------------------
  logic [31:0] rd_nxt;
  always_comb begin
    rd_nxt = 32'h0000_0000;
    unique case (rd_sel_in)
      CRF_SEL_D0:     rd_nxt = {16'h0000, cur_d[15:0]};
      CRF_SEL_D1:     rd_nxt = {16'h0000, cur_d[31:16]};
      CRF_SEL_D2:     rd_nxt = {16'h0000, cur_d[47:32]};
      CRF_SEL_D3:     rd_nxt = {16'h0000, cur_d[63:48]};
      CRF_SEL_D0L:    rd_nxt = {24'h000000, cur_d[7:0]};
      CRF_SEL_D0H:    rd_nxt = {24'h000000, cur_d[15:8]}; // RQ2
      CRF_SEL_D1L:    rd_nxt = {24'h000000, cur_d[23:16]};
      CRF_SEL_D1H:    rd_nxt = {24'h000000, cur_d[31:24]};
      CRF_SEL_LONGLO: rd_nxt = {cur_d[47:32], cur_d[15:0]}; // RQ3
      CRF_SEL_LONGHI: rd_nxt = {cur_d[63:48], cur_d[31:16]}; // RQ3
      CRF_SEL_P0:     rd_nxt = {8'h00, cur_a[23:0]};
      CRF_SEL_P1:     rd_nxt = {8'h00, cur_a[47:24]};
      CRF_SEL_SB:     rd_nxt = {8'h00, cur_a[71:48]};
      CRF_SEL_FB:     rd_nxt = {8'h00, cur_a[95:72]};
      CRF_SEL_VTB:    rd_nxt = {8'h00, vtb_r};
      CRF_SEL_USP:    rd_nxt = {8'h00, usp_r};
      CRF_SEL_ISP:    rd_nxt = {8'h00, isp_r};
      CRF_SEL_SP:     rd_nxt = {8'h00, flg_r[FLG_STACK] ? usp_r : isp_r};
      CRF_SEL_FLG:    rd_nxt = {16'h0000, flg_r & FLG_WMASK}; // RQ19
      CRF_SEL_SVF:    rd_nxt = {16'h0000, svf_r};
      CRF_SEL_SVP:    rd_nxt = {16'h0000, svp_r};
      CRF_SEL_VCT:    rd_nxt = {8'h00, vct_r};
      CRF_SEL_PC:     rd_nxt = {8'h00, pc_r};
      default:        rd_nxt = 32'h0000_0000;
    endcase
  end

  logic [23:0] dma_nxt;
  always_comb begin
    dma_nxt = 24'h000000;
    unique case (dma_rd_sel_in)
      CRF_DMA_MODE:  dma_nxt = {16'h0000, mode_r[dma_rd_chan_in]};
      CRF_DMA_COUNT: dma_nxt = {8'h00, cnt_r[dma_rd_chan_in]};
      CRF_DMA_CRLD:  dma_nxt = {8'h00, crld_r[dma_rd_chan_in]};
      CRF_DMA_MADDR: dma_nxt = maddr_r[dma_rd_chan_in];
      CRF_DMA_FADDR: dma_nxt = faddr_r[dma_rd_chan_in];
      CRF_DMA_ARLD:  dma_nxt = arld_r[dma_rd_chan_in];
      default:       dma_nxt = 24'h000000;
    endcase
  end

  // Reads register one cycle after the select
  always_ff @(posedge sys_clk_in or negedge rstn) begin
    if (!rstn) begin
      rd_data_out     <= 32'h0000_0000;
      dma_rd_data_out <= 24'h000000;
    end else if (ce_in) begin
      rd_data_out     <= rd_nxt;
      dma_rd_data_out <= dma_nxt;
    end
  end

  // ------------------------------------------------------------
  // Direct views for the address generator and sequencer
  // ------------------------------------------------------------
  assign flags_out       = flg_r & FLG_WMASK;
  assign pc_out          = pc_r;
  assign sp_out          = flg_r[FLG_STACK] ? usp_r : isp_r; // RQ10
  assign vtb_out         = vtb_r;
  assign fast_target_out = vct_r;
  assign ptr0_out        = cur_a[23:0];  // RQ4
  assign ptr1_out        = cur_a[47:24];
  assign sb_out          = cur_a[71:48]; // RQ7
  assign fb_out          = cur_a[95:72];

  // Maskable gate: enable flag and strictly higher priority
  assign irq_allowed_out = flg_r[FLG_IEN] &&
                           (req_pri_in > flg_r[FLG_PRI_HI:FLG_PRI_LO]); // RQ18
  assign step_trap_out   = insn_done_in && flg_r[FLG_STEP]; // RQ14

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  chk_flag_reserved: assert property (@(posedge sys_clk_in) // RQ19
    disable iff (!rstn) (flags_out & ~FLG_WMASK) == 16'h0000)
    else $error("reserved flag bits nonzero");
  chk_ack_clears: assert property (@(posedge sys_clk_in) // RQ17
    disable iff (!rstn) ce_in && irq_in.hw_ack |=>
      !flg_r[FLG_IEN] && !flg_r[FLG_STEP] && !flg_r[FLG_STACK])
    else $error("accept did not clear flags");
  chk_swi_stack: assert property (@(posedge sys_clk_in) // RQ11
    disable iff (!rstn) ce_in && irq_in.sw_int && irq_in.sw_num >= 6'h20
      && !irq_in.hw_ack && !irq_in.fast && !(fw && wr_in.sel == CRF_SEL_FLG)
      |=> flg_r[FLG_STACK] == $past(flg_r[FLG_STACK]))
    else $error("high soft interrupt changed stack select");
  chk_carry_cap: assert property (@(posedge sys_clk_in) // RQ13
    disable iff (!rstn) ce_in && alu_in.carry_we |=>
      flg_r[FLG_CARRY] == $past(alu_in.carry))
    else $error("carry not captured");
  chk_fast_save: assert property (@(posedge sys_clk_in) // RQ20
    disable iff (!rstn) ce_in && irq_in.fast |=>
      svf_r == $past(flg_r) && svp_r == $past(pc_r[15:0]))
    else $error("fast save wrong");
  chk_pri_gate: assert property (@(posedge sys_clk_in) // RQ18
    disable iff (!rstn) irq_allowed_out |->
      req_pri_in > flags_out[14:12] && flags_out[FLG_IEN])
    else $error("priority gate wrong");
  chk_sp_select: assert property (@(posedge sys_clk_in) // RQ10
    disable iff (!rstn) sp_out == (flags_out[FLG_STACK] ? usp_r : isp_r))
    else $error("stack select wrong");
  chk_bank_keep: assert property (@(posedge sys_clk_in) // RQ24
    disable iff (!rstn) ce_in && !bank_sel |=>
      bank_d[1] == $past(bank_d[1]) && bank_a[1] == $past(bank_a[1]))
    else $error("unselected bank changed");
  chk_read_lat: assert property (@(posedge sys_clk_in) // RQ3
    disable iff (!rstn) ce_in && rd_sel_in == CRF_SEL_LONGLO && !fw
      |=> rd_data_out == {$past(cur_d[47:32]), $past(cur_d[15:0])})
    else $error("long pair read wrong");

  cov_bank_swap: cover property (@(posedge sys_clk_in) disable iff (!rstn)
    $rose(bank_sel));
  cov_fast_irq: cover property (@(posedge sys_clk_in) disable iff (!rstn)
    ce_in && irq_in.fast);
  cov_swi_low: cover property (@(posedge sys_clk_in) disable iff (!rstn)
    ce_in && irq_in.sw_int && irq_in.sw_num < 6'h20);

endmodule

/* crf_dp_model.sv */
`timescale 1ns/100ps
// ------
// Datapath stand-in
// ------
module crf_dp_model
  import crf_pkg::*;
(
  // Clock
  input  wire logic         clk_in,
  // Updates
  output crf_pkg::crf_alu_t alu_out,
  output crf_pkg::crf_irq_t irq_out,
  output logic              pc_we_out,
  output logic [23:0]       pc_out,
  output logic              done_out,
  output logic [2:0]        pri_out
);
  // Idle until a task pulses something
  initial begin
    alu_out = '0;
    irq_out = '0;
    pc_we_out = 1'b0;
    pc_out = 24'h000000;
    done_out = 1'b0;
    pri_out = 3'h0;
  end
  // Pulses last one cycle, as the real datapath gives
  // One idle edge after each ALU pulse so back-to-back alu calls never re-drive; irq and pc add none
  task automatic alu(input crf_alu_t a);
    alu_out = a;
    @(posedge clk_in);
    #1 alu_out = '0;
    @(posedge clk_in);
    #1;
  endtask
  task automatic irq(input crf_irq_t i);
    irq_out = i;
    @(posedge clk_in);
    #1 irq_out = '0;
  endtask
  // Released load bus shows the inverse, never the stale value
  task automatic pc(input logic [23:0] p);
    pc_we_out = 1'b1;
    pc_out = p;
    @(posedge clk_in);
    #1 pc_we_out = 1'b0;
    pc_out = ~p;
  endtask
  task automatic lvl(input logic [2:0] p, input logic d);
    pri_out = p;
    done_out = d;
  endtask
endmodule

/* tb_cpu_register_file_and_flags.sv */
`timescale 1ns/100ps
module tb_cpu_register_file_and_flags;
  import crf_pkg::*;
  // ------
  // Signals and model state
  // ------
  logic         sys_clk_in, rstn_in, pc_we, done, dch, ok, trap, ce;
  crf_wr_t      wr_in;
  crf_sel_t     rd_sel_in;
  crf_dma_wr_t  dma_wr_in;
  crf_dma_sel_t dsel;
  crf_alu_t     alu;
  crf_irq_t     irq;
  logic [2:0]   pri;
  logic [23:0]  pc, dma_rd, sp, p0;
  logic [31:0]  rd_data, v, seed = 32'h00000039;
  logic [15:0]  processor_flags, m_f;
  logic [23:0]  m_r [2][8];
  int           n_mismatch = 0, check_count = 0, cyc = 0;
  crf_sel_t     z [4] = '{CRF_SEL_VTB, CRF_SEL_USP, CRF_SEL_ISP, CRF_SEL_FLG};
  crf_sel_t     t [2] = '{CRF_SEL_VTB, CRF_SEL_VCT};
  crf_sel_t     bsel [8] = '{CRF_SEL_D0, CRF_SEL_D1, CRF_SEL_D2, CRF_SEL_D3,
                             CRF_SEL_P0, CRF_SEL_P1, CRF_SEL_SB, CRF_SEL_FB};
  crf_dp_model u_dp (.clk_in(sys_clk_in), .alu_out(alu), .irq_out(irq),
    .pc_we_out(pc_we), .pc_out(pc), .done_out(done), .pri_out(pri));
  crf_top DUT (.sys_clk_in, .rstn_in, .ce_in(ce), .wr_in, .rd_sel_in,
    .dma_wr_in, .dma_rd_chan_in(dch), .dma_rd_sel_in(dsel), .alu_in(alu),
    .pc_we_in(pc_we), .pc_in(pc), .irq_in(irq), .insn_done_in(done),
    .req_pri_in(pri), .rd_data_out(rd_data), .dma_rd_data_out(dma_rd),
    .flags_out(processor_flags), .pc_out(), .sp_out(sp), .vtb_out(),
    .fast_target_out(), .ptr0_out(p0), .ptr1_out(), .sb_out(),
    .fb_out(), .irq_allowed_out(ok), .step_trap_out(trap));
  // Clock and hang guard
  initial begin
    sys_clk_in = 1'b0;
    forever #25 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Every drive lands 1 ns after an edge
  task automatic step;
    @(posedge sys_clk_in);
    #1;
  endtask
  task automatic wr(input crf_sel_t s, input logic [31:0] d);
    wr_in = '{1'b1, s, d};
    step();
    wr_in.wr = 1'b0;
    step();
  endtask
  task automatic rd(input crf_sel_t s, input logic [31:0] e);
    rd_sel_in = s;
    step();
    chk(rd_data, e);
  endtask
  task automatic dmr(input logic c, input crf_dma_sel_t s, input logic [31:0] e);
    dch = c;
    dsel = s;
    step();
    chk({8'h00, dma_rd}, e);
  endtask
  task automatic setf(input logic [15:0] f);
    wr(CRF_SEL_FLG, {16'h0000, f});
    m_f = f & FLG_WMASK;
  endtask
  function automatic logic [31:0] rnd;
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Main sequence
  initial begin
    rstn_in = 1'b0;
    ce = 1'b1;
    wr_in = '0;
    rd_sel_in = CRF_SEL_D0;
    dma_wr_in = '0;
    dch = 1'b0;
    dsel = CRF_DMA_MODE;
    repeat (4) @(posedge sys_clk_in);
    #1 rstn_in = 1'b1;
    repeat (3) step();
    foreach (bsel[i]) rd(bsel[i], 32'h0);
    foreach (z[i]) rd(z[i], 32'h0);
    dmr(1'b0, CRF_DMA_MODE, 32'h0);
    dmr(1'b1, CRF_DMA_MODE, 32'h0);
    // Fill both banks, then read back: no copying on a switch
    for (int b = 0; b < 2; b++) begin
      setf(b ? 16'h0010 : 16'h0000);
      foreach (bsel[i]) begin
        v = rnd() & (i < 4 ? 32'hFFFF : 32'hFFFFFF);
        wr(bsel[i], v);
        m_r[b][i] = v[23:0];
      end
    end
    for (int b = 0; b < 2; b++) begin
      setf(b ? 16'h0010 : 16'h0000);
      chk(p0, m_r[b][4]);
      foreach (bsel[i]) rd(bsel[i], m_r[b][i]);
    end
    wr(CRF_SEL_D0H, 32'h000000A5);
    wr(CRF_SEL_D1L, 32'h0000005A);
    m_r[1][0][15:8] = 8'hA5;
    m_r[1][1][7:0] = 8'h5A;
    rd(CRF_SEL_D0, m_r[1][0]);
    rd(CRF_SEL_D1, m_r[1][1]);
    rd(CRF_SEL_LONGLO, {m_r[1][2][15:0], m_r[1][0][15:0]});
    v = rnd();
    wr(CRF_SEL_LONGHI, v);
    rd(CRF_SEL_D3, v[31:16]);
    rd(CRF_SEL_D1, v[15:0]);
    wr(CRF_SEL_USP, 32'h00001234);
    wr(CRF_SEL_ISP, 32'h00005678);
    setf(16'hFFFF);
    rd(CRF_SEL_FLG, 32'h000070FF);
    chk(sp, 24'h001234);
    setf(16'h0000);
    chk(sp, 24'h005678);
    // Random ALU flag updates, enables included
    repeat (8) begin
      v = rnd();
      u_dp.alu(v[7:0]);
      if (v[7]) m_f[0] = v[6];
      if (v[5]) m_f[2] = v[4];
      if (v[3]) m_f[3] = v[2];
      if (v[1]) m_f[5] = v[0];
      chk(processor_flags, m_f);
    end
    // Priority compare at its boundary, then accept clears
    setf(16'h30C2);
    u_dp.lvl(3'h4, 1'b1);
    step();
    chk(ok, 1'b1);
    chk(trap, 1'b1);
    u_dp.lvl(3'h3, 1'b0);
    step();
    chk(ok, 1'b0);
    chk(trap, 1'b0);
    u_dp.lvl(3'h7, 1'b0);
    u_dp.irq('{1'b1, 1'b0, 6'h00, 1'b0});
    chk(processor_flags, 16'h3000);
    chk(ok, 1'b0);
    for (int n = 31; n < 33; n++) begin
      setf(16'h00C2);
      u_dp.irq('{1'b0, 1'b1, n[5:0], 1'b0});
      chk(processor_flags, n < 32 ? 16'h0000 : 16'h0080);
    end
    // Fast interrupt saves flags and low program counter
    v = rnd();
    u_dp.pc(v[23:0]);
    rd(CRF_SEL_PC, v[23:0]);
    setf(16'h50A5);
    u_dp.irq('{1'b0, 1'b0, 6'h00, 1'b1});
    rd(CRF_SEL_SVF, 32'h000050A5);
    rd(CRF_SEL_SVP, v[15:0]);
    chk(processor_flags, 16'h5025);
    foreach (t[i]) begin
      v = rnd() & 32'hFFFFFF;
      wr(t[i], v);
      rd(t[i], v);
    end
    // Enable low freezes state: the write must not land
    ce = 1'b0;
    wr(CRF_SEL_VCT, 32'h00000000);
    ce = 1'b1;
    rd(CRF_SEL_VCT, v);
    // Transfer channel registers, masked to each width
    for (int c = 0; c < 2; c++) begin
      for (int s = 0; s < 6; s++) begin
        v = rnd() & (s == 0 ? 32'hFF : s < 3 ? 32'hFFFF : 32'hFFFFFF);
        dma_wr_in = '{1'b1, c[0], crf_dma_sel_t'(s), v[23:0]};
        step();
        dma_wr_in.wr = 1'b0;
        dmr(c[0], crf_dma_sel_t'(s), v);
      end
    end
    final_report();
  end
endmodule
